// ---- hw/vts_pkg.sv ----
// Package of constants and carrier types for the vector table select block.
package vts_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam int          ADDR_W          = 24;
    localparam int          IDX_W           = 7;
    localparam logic [23:0] RESET_ADDR      = 24'h000000;
    localparam logic [23:0] PRIMARY_BASE    = 24'h000004;
    localparam logic [23:0] ALT_TABLE_SPAN  = 24'h000100;
    localparam logic [6:0]  ENTRY_COUNT     = 7'h7E;
    localparam logic [6:0]  TRAP_COUNT      = 7'h08;
    localparam logic [6:0]  LAST_ENTRY      = 7'h7D;

    // ****************************************************************
    // Control register layout
    // ****************************************************************
    localparam int          ALT_SEL_BIT     = 15;
    localparam logic [15:0] CTRL2_RESET     = 16'h0000;
    localparam logic [15:0] CTRL2_WMASK     = 16'h8000;

    // Vector fetch request from the core.
    typedef struct packed {
        logic             valid;
        logic [6:0]       index;
    } vts_req_s;

    // Handler address returned to the core.
    typedef struct packed {
        logic             valid;
        logic [23:0]      handler;
    } vts_pc_s;

    // Phases of a vector fetch.
    typedef enum logic [1:0] {
        VTS_IDLE,
        VTS_READ,
        VTS_LOAD
    } vts_state_e;

endpackage

// ---- hw/vts_pick.sv ----
// Natural-priority picker over the pending vector entries.
`timescale 1ns/1ps
module vts_pick (
    input  wire logic [125:0] pend,
    output logic              any,
    output logic [6:0]        index
);

    // Lowest pending entry wins; scan from the top so the lowest is kept last.
    always_comb begin
        any   = 1'b0;
        index = 7'h00;
        for (int i = 125; i >= 0; i--) begin
            if (pend[i]) begin
                any   = 1'b1;
                index = 7'(i);
            end
        end
    end

endmodule

// ---- hw/vts_top.sv ----
// Vector table select and reset entry logic.
// Operation
// - Alternate select set makes every vector fetch read the alternate table.
// - Alternate table starts 0x100 above the primary base, four bytes past the end of the primary table.
// - Both tables share one layout, so an index maps alike.
// - Alternate select is bit 15 of second control register, read and write.
// - Reset is not an exception: no vector fetch or priority for it.
// - Reset clears the registers and forces the program counter to zero.
// - Fetch starts at address zero after reset, where the jump lives.
// - Primary table starts at address four, after the reset jump words.
// - Each entry holds a 24-bit handler address loaded into the counter.
// - Lower table position wins within the same user priority level.
// - Each table holds 126 entries: eight traps then 118 sources.
`timescale 1ns/1ps
module vts_top (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                ctrl2_wr,
    input  wire logic [15:0]         ctrl2_wdata,
    output logic      [15:0]         ctrl2_rdata,
    input  wire logic [125:0]        pend,
    input  wire vts_pkg::vts_req_s   req,
    output logic                     req_ready,
    output logic      [23:0]         mem_addr,
    output logic                     mem_rd,
    input  wire logic [23:0]         mem_rdata,
    output vts_pkg::vts_pc_s         pc_load,
    output logic      [23:0]         pc_reg,
    output logic                     alt_vector_select
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Entry address in the chosen table.
    function automatic logic [23:0] entry_addr(input logic alt, input logic [6:0] idx);
        logic [23:0] base;
        base = alt ? (vts_pkg::PRIMARY_BASE + vts_pkg::ALT_TABLE_SPAN)
                   : vts_pkg::PRIMARY_BASE;
        entry_addr = base + {16'h0000, idx, 1'b0};
    endfunction

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [15:0]              ctrl2_reg;
    vts_pkg::vts_state_e      state_reg;
    logic [6:0]               idx_reg;
    logic                     alt_reg;
    logic                     pick_any;
    logic [6:0]               pick_idx;
    logic [6:0]               sel_idx;

    // Only the select bit is implemented; other bits read as zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl2_reg <= vts_pkg::CTRL2_RESET;
        end else if (ctrl2_wr) begin
            ctrl2_reg <= ctrl2_wdata & vts_pkg::CTRL2_WMASK;
        end
    end

    assign ctrl2_rdata       = ctrl2_reg;
    assign alt_vector_select = ctrl2_reg[vts_pkg::ALT_SEL_BIT];

    // ****************************************************************
    // Vector fetch
    // ****************************************************************
    vts_pick u_pick (
        .pend  (pend),
        .any   (pick_any),
        .index (pick_idx)
    );

    // Explicit request index wins; otherwise the lowest pending entry.
    assign sel_idx   = req.valid ? req.index : pick_idx;
    assign req_ready = (state_reg == vts_pkg::VTS_IDLE);

    // Fetch sequencer: latch index and table, read entry, load counter.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= vts_pkg::VTS_IDLE;
            idx_reg   <= 7'h00;
            alt_reg   <= 1'b0;
        end else begin
            case (state_reg)
                vts_pkg::VTS_IDLE: begin
                    if ((req.valid || pick_any) &&
                        sel_idx <= vts_pkg::LAST_ENTRY) begin
                        idx_reg   <= sel_idx;
                        alt_reg   <= alt_vector_select;
                        state_reg <= vts_pkg::VTS_READ;
                    end
                end
                vts_pkg::VTS_READ: begin
                    state_reg <= vts_pkg::VTS_LOAD;
                end
                vts_pkg::VTS_LOAD: begin
                    state_reg <= vts_pkg::VTS_IDLE;
                end
                default: begin
                    state_reg <= vts_pkg::VTS_IDLE;
                end
            endcase
        end
    end

    // Memory read stands for the read phase.
    assign mem_rd   = (state_reg == vts_pkg::VTS_READ);
    assign mem_addr = mem_rd ? entry_addr(alt_reg, idx_reg) : pc_reg;

    // Program counter: zero at reset, handler address when a vector is taken.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_reg        <= vts_pkg::RESET_ADDR;
            pc_load.valid <= 1'b0;
            pc_load.handler <= vts_pkg::RESET_ADDR;
        end else begin
            pc_load.valid <= 1'b0;
            if (state_reg == vts_pkg::VTS_LOAD) begin
                pc_reg          <= mem_rdata;
                pc_load.valid   <= 1'b1;
                pc_load.handler <= mem_rdata;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_take;
        state_reg == vts_pkg::VTS_IDLE && (req.valid || pick_any) &&
            sel_idx <= vts_pkg::LAST_ENTRY;
    endsequence

    sequence s_read;
        mem_rd;
    endsequence

    sequence s_load;
        pc_load.valid;
    endsequence

    a_alt_addr_pick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_take ##1 1'b1 |-> mem_rd && mem_addr ==
            ($past(alt_vector_select) ? vts_pkg::PRIMARY_BASE + vts_pkg::ALT_TABLE_SPAN
                                      : vts_pkg::PRIMARY_BASE) + {16'h0000, idx_reg, 1'b0})
        else $error("Vector address does not follow table select.");

    a_alt_base_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rd && alt_reg |-> mem_addr >= 24'h000104 && mem_addr <= 24'h0001FE)
        else $error("Alternate entry outside alternate table.");

    a_primary_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rd && !alt_reg |-> mem_addr >= 24'h000004 && mem_addr <= 24'h0000FE)
        else $error("Primary entry outside primary table.");

    a_sel_bit_rw: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl2_wr |=> ctrl2_rdata == {$past(ctrl2_wdata[15]), 15'h0000})
        else $error("Select bit write not reflected.");

    a_reset_clear: assert property (@(posedge clk_sys)
        !rst_n |=> pc_reg == 24'h000000 && ctrl2_rdata == 16'h0000 && !mem_rd)
        else $error("Reset did not clear registers.");

    a_reset_no_fetch: assert property (@(posedge clk_sys)
        !rst_n |=> !mem_rd ##1 !pc_load.valid)
        else $error("Reset caused a vector fetch.");

    a_handler_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rd ##1 1'b1 |=> pc_load.valid && pc_reg == $past(mem_rdata, 1))
        else $error("Handler address not loaded.");

    a_lowest_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_take ##0 (!req.valid && pend[0]) |=> idx_reg == 7'h00)
        else $error("Lowest pending entry not chosen.");

    a_index_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rd |-> idx_reg <= vts_pkg::LAST_ENTRY)
        else $error("Entry index beyond table.");

    a_fetch_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_take |=> s_read ##2 s_load)
        else $error("Vector fetch steps out of order.");

    a_read_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_read |=> !mem_rd)
        else $error("Entry read held longer than one cycle.");

    a_load_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_load |=> !pc_load.valid)
        else $error("Counter load held longer than one cycle.");

    a_handler_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_load |-> pc_load.handler == pc_reg)
        else $error("Handler differs from program counter.");

    a_pc_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg != vts_pkg::VTS_LOAD |=> $stable(pc_reg))
        else $error("Program counter moved without a vector load.");

    a_req_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_take ##0 req.valid |=> idx_reg == $past(req.index))
        else $error("Requested index not kept.");

    a_refuse_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == vts_pkg::VTS_IDLE && req.valid && req.index > vts_pkg::LAST_ENTRY
            |=> !mem_rd)
        else $error("Index beyond table started a read.");

    a_entry_even: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_read |-> !mem_addr[0])
        else $error("Entry address is odd.");

    a_ctrl_unused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl2_rdata & ~vts_pkg::CTRL2_WMASK) == 16'h0000)
        else $error("Unused control bits read nonzero.");

    a_reset_entry: assert property (@(posedge clk_sys)
        !rst_n |=> mem_addr == vts_pkg::RESET_ADDR)
        else $error("Fetch address not zero after reset.");

    a_reset_ready: assert property (@(posedge clk_sys)
        !rst_n |=> req_ready && !pc_load.valid)
        else $error("Reset left a fetch in progress.");

endmodule

// ---- testbench/vts_mem_model.sv ----
// Program memory model that answers vector entry reads.
`timescale 1ns/1ps
module vts_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_rd,
    input  wire logic [23:0] mem_addr,
    output logic      [23:0] mem_rdata
);
    // Starts from a known pattern so the toggling below never holds an unknown.
    logic [23:0] data_reg = 24'h3C3C3C;
    // Each entry holds a 24-bit handler image of its own address.
    // Outside an answer the bus toggles, so stale data never passes for an entry.
    always @(posedge clk_sys) begin
        if (mem_rd) begin
            data_reg <= mem_addr ^ 24'hA5A5A5;
        end else begin
            data_reg <= ~data_reg;
        end
    end
    // The answer bus shows the model's one data register.
    assign mem_rdata = data_reg;
endmodule

// ---- testbench/vts_top_tb.sv ----
// Self-checking bench for the vector table select block.
`timescale 1ns/1ps
module vts_top_tb;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  ctrl2_wr = 1'b0;
    logic [15:0]           ctrl2_wdata = 16'h0000;
    logic [15:0]           ctrl2_rdata;
    logic [125:0]          pend = '0;
    vts_pkg::vts_req_s     req = '0;
    logic                  req_ready;
    logic [23:0]           mem_addr;
    logic                  mem_rd;
    logic [23:0]           mem_rdata;
    vts_pkg::vts_pc_s      pc_load;
    logic [23:0]           pc_reg;
    logic                  alt_vector_select;
    logic [6:0]            ids [4] = '{7'h00, 7'h07, 7'h08, 7'h7D};
    int                    errors = 0;
    int                    tests_run = 0;

    // The clock runs at 40 MHz.
    always #12.5 clk_sys = ~clk_sys;

    vts_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl2_wr(ctrl2_wr),
        .ctrl2_wdata(ctrl2_wdata), .ctrl2_rdata(ctrl2_rdata), .pend(pend), .req(req),
        .req_ready(req_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .pc_load(pc_load), .pc_reg(pc_reg), .alt_vector_select(alt_vector_select));
    vts_mem_model mem (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one flag and reports a mismatch at once.
    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // Holds reset with sources pending, optionally cutting a fetch, and checks no fetch.
    task automatic do_reset(input logic busy);
        @(negedge clk_sys);
        if (busy) begin
            req = '{1'b1, 7'h05};
            @(negedge clk_sys);
            req = '0;
            chk_flag(mem_rd, 1'b1);
        end
        rst_n = 1'b0;
        pend = '1;
        repeat (8) begin
            @(negedge clk_sys);
            chk_flag(mem_rd | pc_load.valid, 1'b0);
            chk_flag(req_ready, 1'b1);
        end
        chk(pc_reg, 24'h000000);
        chk(pc_load.handler, 24'h000000);
        chk(mem_addr, 24'h000000);
        chk({8'h00, ctrl2_rdata}, 24'h000000);
        pend = '0;
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk_flag(mem_rd | pc_load.valid, 1'b0);
        chk(mem_addr, 24'h000000);
    endtask

    // Writes the control register and checks that only the select bit stays.
    task automatic wr_ctrl(input logic [15:0] d);
        @(negedge clk_sys);
        ctrl2_wr = 1'b1;
        ctrl2_wdata = d;
        @(negedge clk_sys);
        ctrl2_wr = 1'b0;
        chk({8'h00, ctrl2_rdata}, {8'h00, d & 16'h8000});
        chk_flag(alt_vector_select, d[15]);
    endtask

    // Runs one fetch, by request and/or pending mask, and checks every cycle of it.
    task automatic fetch(input logic [6:0] idx, input logic alt, input logic [125:0] pm,
                         input logic by_req);
        logic [23:0] addr;
        addr = (alt ? 24'h000104 : 24'h000004) + {16'h0000, idx, 1'b0};
        @(negedge clk_sys);
        chk_flag(req_ready, 1'b1);
        pend = pm;
        if (by_req) req = '{1'b1, idx};
        @(negedge clk_sys);
        pend = '0;
        req = '0;
        chk_flag(mem_rd, 1'b1);
        chk_flag(req_ready, 1'b0);
        chk(mem_addr, addr);
        @(negedge clk_sys);
        chk_flag(mem_rd | pc_load.valid, 1'b0);
        @(negedge clk_sys);
        chk_flag(pc_load.valid, 1'b1);
        chk_flag(req_ready, 1'b1);
        chk(pc_load.handler, addr ^ 24'hA5A5A5);
        chk(pc_reg, addr ^ 24'hA5A5A5);
        @(negedge clk_sys);
        chk_flag(pc_load.valid, 1'b0);
        chk(mem_addr, addr ^ 24'hA5A5A5);
    endtask

    // Offers an index beyond the table and checks that no read starts.
    task automatic refuse(input logic [6:0] idx);
        @(negedge clk_sys);
        req = '{1'b1, idx};
        repeat (3) begin
            @(negedge clk_sys);
            chk_flag(mem_rd, 1'b0);
            chk_flag(req_ready, 1'b1);
        end
        req = '0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Sequence and watchdog
    // ************************************************************
    // Main sequence of scenarios.
    initial begin
        do_reset(1'b0);
        wr_ctrl(16'h7FFF);
        foreach (ids[i]) fetch(ids[i], 1'b0, '0, 1'b1);
        fetch(7'h00, 1'b0, 126'h1 | (126'h1 << 125), 1'b0);
        wr_ctrl(16'hFFFF);
        foreach (ids[i]) fetch(ids[i], 1'b1, '0, 1'b1);
        fetch(7'h09, 1'b1, (126'h1 << 9) | (126'h1 << 40), 1'b0);
        fetch(7'h20, 1'b1, 126'h1, 1'b1);
        refuse(7'h7E);
        refuse(7'h7F);
        wr_ctrl(16'h7FFF);
        fetch(7'h08, 1'b0, '0, 1'b1);
        wr_ctrl(16'h8000);
        do_reset(1'b1);
        fetch(7'h03, 1'b0, '0, 1'b1);
        finish_test();
    end

    // Cuts a hang short well after the expected hundred or so cycles.
    initial begin
        #100000;
        errors++;
        finish_test();
    end
endmodule
